/* rtl/sync_rx_pkg.sv */
// Constants shared by the synchronous slave receiver and its FIFO
package sync_rx_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 9;
    localparam int FIFO_DEPTH = 2;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_BIT_8 = 4'h7;
    localparam logic [CNT_W-1:0] LAST_BIT_9 = 4'h8;
    // Byte offsets of the word-aligned registers
    localparam logic [ADDR_W-1:0] OFS_RX_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TX_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_BAUD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_CTRL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_PIE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PIR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_POWER = 8'h24;
    // receive_status_control fields
    localparam int PORT_EN_B = 7;
    localparam int NINE_BIT_B = 6;
    localparam int CONT_RX_B = 4;
    localparam int OVR_ERR_B = 1;
    localparam int NINTH_B = 0;
    localparam logic [7:0] RX_STATUS_WMASK = 8'hf8;
    // transmit_status_control fields
    localparam int CLK_SRC_B = 7;
    localparam int SYNC_B = 4;
    localparam int TRMT_B = 1;
    // baud_control fields
    localparam int RCIDL_B = 6;
    localparam int SCKP_B = 4;
    localparam logic [7:0] BAUD_WMASK = 8'h9b;
    // interrupt_control, peripheral enable and flag fields
    localparam int GLOBAL_IE_B = 7;
    localparam int PERIPH_IE_B = 6;
    localparam int RX_IE_B = 5;
    localparam int RX_IF_B = 5;
    localparam logic [7:0] PIE_WMASK = 8'hf3;
    localparam logic [7:0] PIR_WMASK = 8'hd3;
    // Event status and mask layout
    localparam int EVT_W = 2;
    localparam int EVT_CHAR_B = 0;
    localparam int EVT_OVR_B = 1;
    localparam int SLEEP_B = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
    typedef enum logic [1:0] {
        RX_OFF = 2'b00,
        RX_SHIFT = 2'b01,
        RX_HALT = 2'b10
    } rx_state_t;
endpackage

/* rtl/rx_fifo.sv */
// Two-entry receive FIFO holding nine-bit characters
`timescale 1ns/1ps
module rx_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // Fill side
    input wire logic push_valid,
    output logic push_ready,
    input wire logic [sync_rx_pkg::WORD_W-1:0] push_data,
    // Drain side
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [sync_rx_pkg::WORD_W-1:0] pop_data
);
    import sync_rx_pkg::*;

    logic [WORD_W-1:0] mem_q [FIFO_DEPTH];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic do_push;
    logic do_pop;

    assign push_ready = (count_q != 2'(FIFO_DEPTH));
    assign pop_valid = (count_q != 2'h0);
    assign pop_data = mem_q[rd_ptr_q];
    assign do_push = push_valid & push_ready;
    assign do_pop = pop_ready & pop_valid;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            wr_ptr_q <= wr_ptr_q ^ do_push;
            rd_ptr_q <= rd_ptr_q ^ do_pop;
            count_q <= count_q + 2'(do_push) - 2'(do_pop);
        end
    end
endmodule // rx_fifo

/* rtl/sync_slave_serial_receiver.sv */
// Synchronous slave receive path of the enhanced serial port with Avalon-MM registers
//
// Summary of operation
// R1: Slave mode receives continuously while port is on
// R2: single_receive_enable is ignored in slave mode
// R3: Sleep reception needs continuous_receive_enable set beforehand
// R4: Completed word moves from shift reg to data
// R5: Enabled receive interrupt wakes device from Sleep
// R6: With global enable, wake branches to vector
// R7: Software selects sync, port enable, external clock
// R8: Software clears analog select on both pins; the pins here have no analog select, so the set-up clears none
// R9: nine_bit_receive_enable selects 9-bit, else 8-bit
// R10: receive_int_flag set on completion, interrupt if enabled
// R11: Ninth bit in status register, low eight in data
// R12: Clearing continuous or port enable clears overrun
// R13: Data read returns and removes oldest character
// R14: Data sampled on clock edge, LSB first
// R15: Full FIFO completion sets overrun, halts reception
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module sync_slave_serial_receiver (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [sync_rx_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [sync_rx_pkg::DATA_W-1:0] avs_writedata,
    output logic [sync_rx_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial link from the external master
    input wire logic sync_clock_pin,
    input wire logic sync_data_pin,
    // Interrupt and power status
    output logic irq,
    output logic asleep,
    output logic wake,
    output logic branch_to_vector
);
    import sync_rx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Link synchronisers
    logic lclk_s1_q, lclk_s2_q, lclk_s3_q, ldat_s1_q, ldat_s2_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
            ldat_s1_q <= 1'b0;
            ldat_s2_q <= 1'b0;
        end else begin
            lclk_s1_q <= sync_clock_pin;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
            ldat_s1_q <= sync_data_pin;
            ldat_s2_q <= ldat_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] rx_status_q, tx_status_q, baud_q, int_ctrl_q, pie_q, pir_q;
    logic [EVT_W-1:0] evt_stat_q, evt_mask_q, evt_set;
    logic sleep_q, wait_q, pop_armed_q, ovr_q;
    logic [DATA_W-1:0] rdata_q;
    logic irq_q, wake_q, vector_q;
    rx_state_t state_q, state_d;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [WORD_W-1:0] shift_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode: one wait state, the access completes when waitrequest is low
    logic req, done, wr8, pop;
    logic sel_rxs, sel_txs, sel_baud, sel_intc, sel_pie, sel_pir;
    logic sel_data, sel_evs, sel_evm, sel_pwr;
    logic [7:0] wb, rd_byte;
    logic fifo_valid, fifo_ready;
    logic [WORD_W-1:0] fifo_head;

    assign req = avs_read | avs_write;
    assign done = req & ~wait_q;
    assign wr8 = avs_write & done & avs_byteenable[0];
    assign wb = avs_writedata[7:0];
    assign sel_rxs = (avs_address == OFS_RX_STATUS);
    assign sel_txs = (avs_address == OFS_TX_STATUS);
    assign sel_baud = (avs_address == OFS_BAUD);
    assign sel_intc = (avs_address == OFS_INT_CTRL);
    assign sel_pie = (avs_address == OFS_PIE);
    assign sel_pir = (avs_address == OFS_PIR);
    assign sel_data = (avs_address == OFS_RX_DATA);
    assign sel_evs = (avs_address == OFS_EVT_STAT);
    assign sel_evm = (avs_address == OFS_EVT_MASK);
    assign sel_pwr = (avs_address == OFS_POWER);

    // Status views mix stored bits with live receiver state
    logic [7:0] rxs_view, txs_view, baud_view, pir_view;
    // An empty FIFO shows a zero ninth bit rather than stale or unwritten storage
    assign rxs_view = {rx_status_q[7:3], 1'b0, ovr_q, fifo_valid & fifo_head[WORD_W-1]}; // [R11]
    assign txs_view = tx_status_q | (8'h01 << TRMT_B);
    assign baud_view = baud_q | (8'((state_q != RX_SHIFT) || (bit_cnt_q == '0)) << RCIDL_B);
    assign pir_view = pir_q | (8'(fifo_valid) << RX_IF_B); // [R10]

    assign rd_byte = sel_rxs ? rxs_view :
                     sel_txs ? txs_view :
                     sel_baud ? baud_view :
                     sel_intc ? int_ctrl_q :
                     sel_pie ? pie_q :
                     sel_pir ? pir_view :
                     sel_data ? (fifo_valid ? fifo_head[7:0] : 8'h00) :
                     sel_evs ? 8'(evt_stat_q) :
                     sel_evm ? 8'(evt_mask_q) :
                     sel_pwr ? 8'(sleep_q) : 8'h00;

    // Pop only a character that was shown in the captured read data
    assign pop = done & avs_read & pop_armed_q; // [R13]

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            pop_armed_q <= 1'b0;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q) begin
                rdata_q <= {24'h000000, rd_byte};
                pop_armed_q <= avs_read & sel_data & fifo_valid;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic cont_rx_clear, port_off;
    assign cont_rx_clear = wr8 & sel_rxs & ~wb[CONT_RX_B] & rx_status_q[CONT_RX_B];
    assign port_off = ~rx_status_q[PORT_EN_B];

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_status_q <= REG_RESET;
            tx_status_q <= REG_RESET;
            baud_q <= REG_RESET;
            int_ctrl_q <= REG_RESET;
            pie_q <= REG_RESET;
            pir_q <= REG_RESET;
            evt_mask_q <= '0;
        end else begin
            if (wr8 && sel_rxs) rx_status_q <= wb & RX_STATUS_WMASK;
            if (wr8 && sel_txs) tx_status_q <= wb & ~(8'h01 << TRMT_B);
            if (wr8 && sel_baud) baud_q <= wb & BAUD_WMASK;
            if (wr8 && sel_intc) int_ctrl_q <= wb;
            if (wr8 && sel_pie) pie_q <= wb & PIE_WMASK;
            if (wr8 && sel_pir) pir_q <= wb & PIR_WMASK;
            if (wr8 && sel_evm) evt_mask_q <= wb[EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver
    logic port_on, rx_allowed, lclk_edge, last_bit, char_done, push, overrun_set;
    logic [WORD_W-1:0] word_in;

    // The single-shot enable never enters this term: slave reception ignores it [R2]
    assign port_on = rx_status_q[PORT_EN_B] & tx_status_q[SYNC_B] & ~tx_status_q[CLK_SRC_B];
    // Awake the receiver never idles; asleep it needs the continuous enable [R1] [R3]
    assign rx_allowed = port_on & (~sleep_q | rx_status_q[CONT_RX_B]);
    // Polarity bit picks the sampling edge of the external clock
    assign lclk_edge = (lclk_s2_q ^ lclk_s3_q) & (lclk_s2_q ^ baud_q[SCKP_B]); // [R14]
    assign last_bit = (bit_cnt_q == (rx_status_q[NINE_BIT_B] ? LAST_BIT_9 : LAST_BIT_8)); // [R9]
    assign char_done = (state_q == RX_SHIFT) & rx_allowed & lclk_edge & last_bit;
    assign push = char_done & fifo_ready; // [R4]
    assign overrun_set = char_done & ~fifo_ready; // [R15]
    assign word_in = rx_status_q[NINE_BIT_B] ? {ldat_s2_q, shift_q[7:0]} :
                     {1'b0, ldat_s2_q, shift_q[6:0]};

    always_comb begin
        state_d = state_q;
        case (state_q)
            RX_OFF: begin
                // An overrun outlives a mode change, so re-entry stays halted until cleared
                if (port_on) state_d = ovr_q ? RX_HALT : RX_SHIFT; // [R15]
            end
            RX_SHIFT: begin
                if (!port_on) state_d = RX_OFF;
                else if (overrun_set) state_d = RX_HALT; // [R15]
            end
            RX_HALT: begin
                if (!port_on) state_d = RX_OFF;
                else if (!ovr_q) state_d = RX_SHIFT;
            end
            default: state_d = RX_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= RX_OFF;
            bit_cnt_q <= '0;
            shift_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q != RX_SHIFT || !port_on) begin
                bit_cnt_q <= '0;
            end else if (lclk_edge && rx_allowed) begin
                shift_q[bit_cnt_q] <= ldat_s2_q; // [R14]
                bit_cnt_q <= last_bit ? '0 : bit_cnt_q + 4'h1;
            end
        end
    end

    // Overrun: a new error wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_q <= 1'b0;
        end else if (overrun_set) begin
            ovr_q <= 1'b1;
        end else if (cont_rx_clear || port_off) begin
            ovr_q <= 1'b0; // [R12]
        end
    end

    rx_fifo u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(port_off),
        .push_valid(push),
        .push_ready(fifo_ready),
        .push_data(word_in),
        .pop_valid(fifo_valid),
        .pop_ready(pop),
        .pop_data(fifo_head)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Events, interrupt and sleep wake-up
    logic wake_cond;
    assign evt_set = {overrun_set, push};
    assign wake_cond = sleep_q & fifo_valid & pie_q[RX_IE_B]; // [R5]

    always_ff @(posedge clk) begin
        if (rst) begin
            evt_stat_q <= '0;
            sleep_q <= 1'b0;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
            vector_q <= 1'b0;
        end else begin
            // Hardware set wins over the write-one clear
            evt_stat_q <= (evt_stat_q & ~((wr8 & sel_evs) ? wb[EVT_W-1:0] : '0)) | evt_set;
            irq_q <= |(evt_stat_q & evt_mask_q);
            if (wake_cond) begin
                sleep_q <= 1'b0; // [R5]
            end else if (wr8 && sel_pwr) begin
                sleep_q <= wb[SLEEP_B];
            end
            wake_q <= wake_cond;
            vector_q <= wake_cond & int_ctrl_q[GLOBAL_IE_B] & int_ctrl_q[PERIPH_IE_B]; // [R6]
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq = irq_q;
    assign asleep = sleep_q;
    assign wake = wake_q;
    assign branch_to_vector = vector_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_push_lands;
        @(posedge clk) disable iff (rst) push |=> fifo_valid;
    endproperty
    a_push_lands: assert property (p_push_lands) else $error("character not stored"); // [R4]

    property p_overrun_sets;
        @(posedge clk) disable iff (rst) overrun_set |=> ovr_q && state_q == RX_HALT;
    endproperty
    a_overrun_sets: assert property (p_overrun_sets) else $error("overrun not flagged"); // [R15]

    property p_halt_blocks;
        @(posedge clk) disable iff (rst) ovr_q |-> !push;
    endproperty
    a_halt_blocks: assert property (p_halt_blocks) else $error("push during overrun"); // [R15]

    property p_ovr_clears;
        @(posedge clk) disable iff (rst) (cont_rx_clear && !overrun_set) |=> !ovr_q;
    endproperty
    a_ovr_clears: assert property (p_ovr_clears) else $error("overrun not cleared"); // [R12]

    property p_wake;
        @(posedge clk) disable iff (rst)
            (sleep_q && fifo_valid && pie_q[RX_IE_B]) |=> (wake_q && !sleep_q) ##1 !wake_q;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake pulse"); // [R5]

    property p_vector;
        @(posedge clk) disable iff (rst)
            wake_q |-> vector_q == $past(int_ctrl_q[GLOBAL_IE_B] && int_ctrl_q[PERIPH_IE_B]);
    endproperty
    a_vector: assert property (p_vector) else $error("vector branch wrong"); // [R6]

    // An 8-bit character carries no ninth bit, and the count restarts after each one
    property p_width;
        @(posedge clk) disable iff (rst)
            char_done |-> (rx_status_q[NINE_BIT_B] || !word_in[WORD_W-1]) ##1 (bit_cnt_q == '0);
    endproperty
    a_width: assert property (p_width) else $error("wrong character length"); // [R9]

    property p_bit_step;
        @(posedge clk) disable iff (rst)
            (state_q == RX_SHIFT && port_on && rx_allowed && lclk_edge && !last_bit)
            |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1;
    endproperty
    a_bit_step: assert property (p_bit_step) else $error("bit count not advanced"); // [R14]
endmodule // sync_slave_serial_receiver

/* bench/sync_master_model.sv */
// Behavioural external synchronous master driving the link clock and data pins
`timescale 1ns/1ps
module sync_master_model (
    // Clock
    input wire logic clk,
    // Link pins
    output logic sync_clock_pin,
    output logic sync_data_pin
);
    initial begin
        sync_clock_pin = 1'b0;
        sync_data_pin = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One character, LSB first; half is the half period in system clocks and idle the
    // level the clock rests at, so the mid-bit edge is always the sampled one
    task automatic send_char(input logic [8:0] ch, input int nbits, input int half,
                             input logic idle);
        sync_clock_pin <= idle;
        for (int i = 0; i < nbits; i++) begin
            sync_data_pin <= ch[i];
            repeat (half) @(posedge clk);
            sync_clock_pin <= ~idle;
            repeat (half) @(posedge clk);
            sync_clock_pin <= idle;
        end
        // Clock stands still between frames; data line no longer holds the last bit
        sync_data_pin <= ~sync_data_pin;
    endtask
endmodule // sync_master_model

/* bench/sync_slave_serial_receiver_tb.sv */
// Self-checking bench for the synchronous slave receiver
`timescale 1ns/1ps
module sync_slave_serial_receiver_tb;
    import sync_rx_pkg::*;
    logic clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic sync_clock_pin, sync_data_pin, irq, asleep, wake, branch_to_vector;
    logic saw_wake, saw_br;
    int mismatches, num_checks;

    sync_slave_serial_receiver sync_slave_serial_receiver_i (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sync_clock_pin(sync_clock_pin),
        .sync_data_pin(sync_data_pin), .irq(irq), .asleep(asleep), .wake(wake),
        .branch_to_vector(branch_to_vector)
    );
    sync_master_model sync_master_model_i (
        .clk(clk), .sync_clock_pin(sync_clock_pin), .sync_data_pin(sync_data_pin)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Wake and vector are single-cycle pulses, so latch them for later inspection
    always @(posedge clk) begin
        if (wake === 1'b1) saw_wake <= 1'b1;
        if (branch_to_vector === 1'b1) saw_br <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Hold the request until waitrequest is seen low, then release and idle one edge;
    // only the watchdog ends a wait that never completes
    task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= wd;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] unused;
        bus_op(1'b1, a, {24'h0, d}, unused);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        bus_op(1'b0, a, 32'h0, d);
        chk(d & m, e);
    endtask

    task automatic rx(input logic [8:0] ch, input int nbits);
        // Four system clocks a half period give the 800 ns link clock
        sync_master_model_i.send_char(ch, nbits, 4, 1'b0);
        repeat (6) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hf;
        avs_writedata = 32'h0;
        saw_wake = 1'b0;
        saw_br = 1'b0;
        mismatches = 0;
        num_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        // Reset values, unmapped address, ignored lane
        rdchk(OFS_RX_STATUS, 32'hffffffff, 32'h0);
        rdchk(OFS_TX_STATUS, 32'hffffffff, 32'h02);
        avs_byteenable <= 4'h0;
        wr(OFS_PIE, 8'hff);
        avs_byteenable <= 4'hf;
        rdchk(OFS_PIE, 32'hffffffff, 32'h0);
        rdchk(8'h40, 32'hffffffff, 32'h0);
        // Slave set-up, continuous enable clear and single-shot enable set: reception runs.
        // The pins here have no analog select, so the set-up has none to clear.
        wr(OFS_TX_STATUS, 8'h10);
        wr(OFS_RX_STATUS, 8'ha0);
        rx(9'h0a5, 8);
        rdchk(OFS_PIR, 32'h20, 32'h20);
        rdchk(OFS_EVT_STAT, 32'h1, 32'h1);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'ha5);
        rdchk(OFS_PIR, 32'h20, 32'h0);
        // Interrupt: masked, unmasked, cleared
        wr(OFS_EVT_STAT, 8'h03);
        wr(OFS_EVT_MASK, 8'h00);
        rx(9'h03c, 8);
        chk({31'h0, irq}, 32'h0);
        // The interrupt output is registered one edge behind status and mask
        wr(OFS_EVT_MASK, 8'h01);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_EVT_STAT, 8'h01);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'h3c);
        // Nine-bit characters, ninth bit both ways
        wr(OFS_RX_STATUS, 8'hc0);
        rx(9'h13c, 9);
        rdchk(OFS_RX_STATUS, 32'h1, 32'h1);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'h3c);
        rx(9'h0c3, 9);
        rdchk(OFS_RX_STATUS, 32'h1, 32'h0);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'hc3);
        // Overrun: third character into a full FIFO, then halted
        wr(OFS_RX_STATUS, 8'h90);
        rx(9'h011, 8);
        rx(9'h022, 8);
        rx(9'h033, 8);
        rdchk(OFS_RX_STATUS, 32'h2, 32'h2);
        rdchk(OFS_EVT_STAT, 32'h2, 32'h2);
        rx(9'h044, 8);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'h11);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'h22);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'h0);
        wr(OFS_RX_STATUS, 8'h80);
        rdchk(OFS_RX_STATUS, 32'h2, 32'h0);
        // Falling-edge sampling with the link clock resting high
        wr(OFS_BAUD, 8'h10);
        sync_master_model_i.send_char(9'h055, 8, 4, 1'b1);
        repeat (6) @(posedge clk);
        rdchk(OFS_RX_DATA, 32'hffffffff, 32'h55);
        wr(OFS_BAUD, 8'h00);
        // Sleep reception: wake without and with the global enables
        wr(OFS_RX_STATUS, 8'h90);
        wr(OFS_PIE, 8'h20);
        for (int g = 0; g < 2; g++) begin
            wr(OFS_INT_CTRL, g ? 8'hc0 : 8'h00);
            wr(OFS_POWER, 8'h01);
            chk({31'h0, asleep}, 32'h1);
            saw_wake <= 1'b0;
            saw_br <= 1'b0;
            rx(9'h05a, 8);
            chk({31'h0, saw_wake}, 32'h1);
            chk({31'h0, saw_br}, g);
            chk({31'h0, asleep}, 32'h0);
            rdchk(OFS_RX_DATA, 32'hffffffff, 32'h5a);
        end
        // Asleep with the continuous enable clear: character refused, no wake
        wr(OFS_RX_STATUS, 8'h80);
        wr(OFS_POWER, 8'h01);
        saw_wake <= 1'b0;
        rx(9'h07c, 8);
        chk({31'h0, saw_wake}, 32'h0);
        chk({31'h0, asleep}, 32'h1);
        rdchk(OFS_PIR, 32'h20, 32'h0);
        wr(OFS_POWER, 8'h00);
        report_and_stop();
    end

    // Whole run is about a thousand cycles; this margin only catches a hang
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule // sync_slave_serial_receiver_tb
